// ==== src/input_glitch_filter.sv ====
// Input glitch and debounce filter with an APB register file.
// Assumes line inputs and the external timebase are synchronous to pclk.
// Contract
// - Suppress changes shorter than the configured time
// - Parallel width: 50 ns plus 25 ns steps
// - One shared parallel width for all lines
// - Parallel: half the pass width always blocked
// - Parallel lines: no presets, no external timebase
// - Filter on after reset, 0.1 ms width
// - Sync option resamples on the fastest clock
// - Per line: preset widths or the custom width
// - Only one custom width shared by all
// - Pass full width, block half width pulses
// - Custom width from 32-bit utility counter
// - Filter and sync never enabled together
// - Presets of 90 ns, 5.12 us, 2.56 ms
// - Bus mode merges skewed changes into one
// - One device custom width beside the presets
`timescale 1ns/10ps
`default_nettype none
module input_glitch_filter
   import glitch_filter_pkg::*;
#(
   parameter int          NUM_LINES = 8,          // Lines of port 0, at most 10
   parameter logic [31:0] LONG_CYC  = CYC_2560US  // Cycles of the 2.56 ms preset
) (
   input  wire logic                 pclk,      // APB clock, 40 MHz
   input  wire logic                 presetn,   // Async reset, active low
   input  wire logic                 psel,      // APB select
   input  wire logic                 penable,   // APB enable
   input  wire logic                 pwrite,    // APB write
   input  wire logic [7:0]           paddr,     // APB byte address
   input  wire logic [31:0]          pwdata,    // APB write data
   output logic      [31:0]          prdata,    // APB read data
   output logic                      pready,    // APB ready
   output logic                      pslverr,   // APB error, unmapped address
   input  wire logic [NUM_LINES-1:0] lines_in,  // Raw input lines
   input  wire logic                 ext_tb,    // External filter timebase
   output logic      [NUM_LINES-1:0] lines_out  // Conditioned lines
);

   // Register map, one aligned 32-bit word each
   //   CTRL   : filter enable, resample enable, bus mode, timebase pin
   //            select; filter wins when both conditioning bits are set
   //   SEL    : three bits per line choose that line's width
   //   DIV    : shared custom divider for the utility counter
   //   RATE   : timebase pin rate; zero means not yet set
   //   PAR    : step count for the shared parallel width
   //   STATUS : live output levels and the timebase in use, read only
   // Any other address answers with an error and reads as zero.
   //
   // Bus timing
   //   Setup cycle, then the access phase; the decode happens on the
   //   first access edge and pready rises for exactly one cycle after
   //   it, so every transfer carries a single wait state.
   //   A write lands on the edge where pready is seen high.
   //   Read data is registered and stands until the next read.
   //
   // Line timing
   //   Raw lines are sampled every edge into a one-stage input register.
   //   With the filter on, a change shows at the output two edges after
   //   the input has stood for the full width of its line.
   //   With only resampling on, the output lags the input by three edges.
   //   With neither, the output lags by two edges.
   //
   // Width choices
   //   Presets count pclk cycles, rounded up to whole cycles so that a
   //   passing pulse is never shorter than the nominal width.
   //   The parallel choice counts pclk only, in single-cycle steps above
   //   a two-cycle floor; it never sees the timebase pin.
   //   The custom choice counts utility ticks: a line flips after two
   //   consecutive differing ticks, so one tick or less is always lost.
   //
   // Utility counter
   //   Counts pclk, or rising edges of the timebase pin once both the
   //   select bit and a non-zero rate are present. A divider of zero is
   //   treated like one so that the tick never stalls.
   //   Its wrap raises one tick for a single cycle.
   //
   // Bus mode
   //   The whole port moves as one word: its counter restarts on every
   //   raw change and the word is taken once nothing moved for the width
   //   of line 0. Per-line counting is held off meanwhile.
   //
   // Hazards
   //   Edge detection on the timebase pin compares against the level seen
   //   one edge earlier; it resets low, matching the pin's idle level, so
   //   release from reset cannot fake a tick.
   //   While the filter is off the filtered levels track the input, which
   //   keeps a stale difference from passing when it is enabled again.
   //   Lowering the width while a count runs may flip a line at once;
   //   software should change widths while lines are quiet.
   //   Counters are 32 bits wide and compare with greater-or-equal, so a
   //   count past a newly smaller threshold still ends cleanly.
   //
   // Outputs
   //   Every output is a field of the state register; nothing combinational
   //   reaches a pin.

   // All state of the block
   typedef struct packed {
      logic                          filt_en;    // Debounce filter on
      logic                          sync_en;    // Resample option on
      logic                          bus_mode;   // Merge port changes
      logic                          ext_en;     // External timebase chosen
      logic [NUM_LINES-1:0][2:0]     sel;        // Width choice per line
      logic [31:0]                   custom_div; // Custom divider, shared
      logic [31:0]                   tb_rate;    // External timebase rate
      logic [15:0]                   par_steps;  // Parallel width steps
      logic [31:0]                   util_cnt;   // Utility counter
      logic                          util_tick;  // Custom filter clock tick
      logic                          tb_q;       // Last timebase level
      logic [NUM_LINES-1:0]          din;        // Sampled inputs
      logic [NUM_LINES-1:0]          s1;         // Resample stage one
      logic [NUM_LINES-1:0]          s2;         // Resample stage two
      logic [NUM_LINES-1:0]          filt;       // Filtered levels
      logic [NUM_LINES-1:0][31:0]    cnt;        // Stability counters
      logic [31:0]                   bus_cnt;    // Port stability counter
      logic [NUM_LINES-1:0]          out;        // Output register
      logic                          pready;     // Bus ready
      logic                          pslverr;    // Bus error
      logic [31:0]                   prdata;     // Bus read data
   } state_t;

   state_t st;       // Current state
   state_t next_st;  // Next state

   logic [NUM_LINES-1:0][31:0] thr;  // Pass threshold per line
   logic [NUM_LINES-1:0]       step; // Counting enable per line
   logic                       ext_active; // External timebase in use
   logic                       tb_evt;     // One timebase event
   logic [31:0]                div_m1;     // Wrap value of utility counter
   logic [31:0]                rd_val;     // Decoded read value
   logic                       hit;        // Address is mapped
   logic                       wr;         // Write takes effect

   // Both source and rate must be set before the pin is used
   assign ext_active = st.ext_en && (st.tb_rate != 32'h0000_0000);
   assign tb_evt     = ext_active ? (st.tb_q == 1'b0 && ext_tb == 1'b1) : 1'b1;
   assign div_m1     = (st.custom_div == 32'h0000_0000) ? 32'h0000_0000
                                                       : st.custom_div - 32'h0000_0001;

   // Threshold and count enable per line
   for (genvar i = 0; i < NUM_LINES; i++) begin : g_thr
      always_comb begin
         step[i] = 1'b1;
         case (st.sel[i])
            SEL_100NS:  thr[i] = CYC_100NS;
            SEL_500NS:  thr[i] = CYC_500NS;
            SEL_90NS:   thr[i] = CYC_90NS;
            SEL_5120NS: thr[i] = CYC_5120NS;
            SEL_2560US: thr[i] = LONG_CYC;
            SEL_100US:  thr[i] = CYC_100US;
            // Shared step width on pclk only, never the timebase pin
            SEL_PAR: begin
               thr[i] = CYC_PAR_MIN
                      + 32'({16'h0000, st.par_steps} * CYC_PAR_STP);
            end
            // Shared custom width counted in utility ticks
            SEL_CUSTOM: begin
               thr[i]  = CUSTOM_TICKS;
               step[i] = st.util_tick;
            end
            default: thr[i] = CYC_100US;
         endcase
      end
   end

   // Register read decode
   always_comb begin
      hit    = 1'b1;
      rd_val = 32'h0000_0000;
      case (paddr)
         OFS_CTRL: begin
            rd_val[CTRL_FILT] = st.filt_en;
            rd_val[CTRL_SYNC] = st.sync_en;
            rd_val[CTRL_BUS]  = st.bus_mode;
            rd_val[CTRL_EXT]  = st.ext_en;
         end
         OFS_SEL:  rd_val = 32'(st.sel);
         OFS_DIV:  rd_val = st.custom_div;
         OFS_RATE: rd_val = st.tb_rate;
         OFS_PAR:  rd_val = {16'h0000, st.par_steps};
         // Live output levels and timebase choice
         OFS_STATUS: begin
            rd_val[NUM_LINES-1:0] = st.out;
            rd_val[STAT_EXT]      = ext_active;
         end
         default: hit = 1'b0;  // Unmapped: error, reads zero
      endcase
   end

   // Write lands on the edge where pready is seen high
   assign wr = psel && penable && pwrite && st.pready && !st.pslverr;

   // Next-state logic
   always_comb begin
      next_st = st;
      // Bus answer one cycle into the access phase
      next_st.pready  = psel && penable && !st.pready;
      next_st.pslverr = 1'b0;
      if (psel && penable && !st.pready) begin
         next_st.pslverr = !hit;
         // Writes leave the last read word standing
         if (!pwrite) begin
            next_st.prdata = hit ? rd_val : 32'h0000_0000;
         end
      end
      if (wr) begin
         case (paddr)
            // Filter wins; sync cannot be set alongside it
            OFS_CTRL: begin
               next_st.filt_en  = pwdata[CTRL_FILT];
               next_st.sync_en  = pwdata[CTRL_SYNC] && !pwdata[CTRL_FILT];
               next_st.bus_mode = pwdata[CTRL_BUS];
               next_st.ext_en   = pwdata[CTRL_EXT];
            end
            OFS_SEL:  next_st.sel        = pwdata[NUM_LINES*3-1:0];
            OFS_DIV:  next_st.custom_div = pwdata;
            OFS_RATE: next_st.tb_rate    = pwdata;
            OFS_PAR:  next_st.par_steps  = pwdata[15:0];
            default: ;
         endcase
      end

      // Input sampling and the two-stage resample
      next_st.din  = lines_in;
      next_st.s1   = lines_in;
      next_st.s2   = st.s1;
      next_st.tb_q = ext_tb;

      // Utility counter divides the timebase into filter ticks
      next_st.util_tick = 1'b0;
      if (tb_evt) begin
         if (st.util_cnt >= div_m1) begin
            next_st.util_cnt  = 32'h0000_0000;
            next_st.util_tick = 1'b1;
         end else begin
            next_st.util_cnt = st.util_cnt + 32'h0000_0001;
         end
      end

      // Per-line stability counting
      for (int i = 0; i < NUM_LINES; i++) begin
         if (!st.filt_en) begin
            // Track the input so enabling starts clean
            next_st.filt[i] = st.din[i];
            next_st.cnt[i]  = 32'h0000_0000;
         end else if (st.din[i] == st.filt[i]) begin
            next_st.cnt[i] = 32'h0000_0000;
         end else if (step[i] && !st.bus_mode) begin
            // Flip only after a full stable width
            if (st.cnt[i] + 32'h0000_0001 >= thr[i]) begin
               next_st.filt[i] = st.din[i];
               next_st.cnt[i]  = 32'h0000_0000;
            end else begin
               next_st.cnt[i] = st.cnt[i] + 32'h0000_0001;
            end
         end
      end

      // Bus mode: port updates as one word after it settles
      next_st.bus_cnt = 32'h0000_0000;
      if (st.filt_en && st.bus_mode) begin
         if (lines_in != st.din) begin
            next_st.bus_cnt = 32'h0000_0000;
         end else if (st.din == st.filt) begin
            next_st.bus_cnt = 32'h0000_0000;
         end else if (step[0]) begin
            if (st.bus_cnt + 32'h0000_0001 >= thr[0]) begin
               next_st.filt = st.din;
            end else begin
               next_st.bus_cnt = st.bus_cnt + 32'h0000_0001;
            end
         end else begin
            next_st.bus_cnt = st.bus_cnt;
         end
      end

      // Output source selection
      if (st.filt_en) begin
         next_st.out = st.filt;
      end else if (st.sync_en) begin
         next_st.out = st.s2;
      end else begin
         next_st.out = st.din;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st            <= '0;
         st.filt_en    <= 1'b1;
         st.sel        <= {NUM_LINES{SEL_100US}};
         st.custom_div <= DIV_RST;
         st.tb_rate    <= RATE_RST;
         st.par_steps  <= PAR_RST;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign prdata    = st.prdata;
   assign pready    = st.pready;
   assign pslverr   = st.pslverr;
   assign lines_out = st.out;

endmodule // input_glitch_filter
`default_nettype wire

// ==== src/glitch_filter_pkg.sv ====
// Constants for the input glitch filter: register map, reset values,
// width selections and cycle counts.
// Assumes a 40 MHz APB clock; every time is rounded up to whole cycles.
package glitch_filter_pkg;
   // Clock period in ns
   localparam int PCLK_NS = 25;
   // Filter widths as printed, in ns
   localparam int T_100NS   = 100;
   localparam int T_500NS   = 500;
   localparam int T_90NS    = 90;
   localparam int T_5120NS  = 5120;
   localparam int T_100US   = 100000;
   localparam int T_2560US  = 2560000;
   localparam int T_PAR_MIN = 50;
   localparam int T_PAR_STP = 25;
   // Least times rounded up to cycles
   localparam logic [31:0] CYC_100NS   = 32'((T_100NS + PCLK_NS - 1) / PCLK_NS);
   localparam logic [31:0] CYC_500NS   = 32'((T_500NS + PCLK_NS - 1) / PCLK_NS);
   localparam logic [31:0] CYC_90NS    = 32'((T_90NS + PCLK_NS - 1) / PCLK_NS);
   localparam logic [31:0] CYC_5120NS  = 32'((T_5120NS + PCLK_NS - 1) / PCLK_NS);
   localparam logic [31:0] CYC_100US   = 32'((T_100US + PCLK_NS - 1) / PCLK_NS);
   localparam logic [31:0] CYC_2560US  = 32'((T_2560US + PCLK_NS - 1) / PCLK_NS);
   localparam logic [31:0] CYC_PAR_MIN = 32'((T_PAR_MIN + PCLK_NS - 1) / PCLK_NS);
   localparam logic [31:0] CYC_PAR_STP = 32'((T_PAR_STP + PCLK_NS - 1) / PCLK_NS);
   // Utility-counter ticks a custom line must stay stable
   localparam logic [31:0] CUSTOM_TICKS = 32'h0000_0002;
   // Per-line width selection codes
   localparam logic [2:0] SEL_100NS  = 3'h0;
   localparam logic [2:0] SEL_500NS  = 3'h1;
   localparam logic [2:0] SEL_90NS   = 3'h2;
   localparam logic [2:0] SEL_5120NS = 3'h3;
   localparam logic [2:0] SEL_2560US = 3'h4;
   localparam logic [2:0] SEL_100US  = 3'h5;
   localparam logic [2:0] SEL_PAR    = 3'h6;
   localparam logic [2:0] SEL_CUSTOM = 3'h7;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_SEL    = 8'h04;
   localparam logic [7:0] OFS_DIV    = 8'h08;
   localparam logic [7:0] OFS_RATE   = 8'h0C;
   localparam logic [7:0] OFS_PAR    = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   // Control bit positions
   localparam int CTRL_FILT = 0;
   localparam int CTRL_SYNC = 1;
   localparam int CTRL_BUS  = 2;
   localparam int CTRL_EXT  = 3;
   // Status bit of the external timebase in use
   localparam int STAT_EXT = 16;
   // Reset values
   localparam logic [31:0] DIV_RST  = 32'h0000_0001;
   localparam logic [31:0] RATE_RST = 32'h0000_0000;
   localparam logic [15:0] PAR_RST  = 16'h0000;
endpackage

// ==== tb/signal_source.sv ====
// Model of the signal sources on the raw lines and external timebase.
// Assumes the bench changes its commands just after rising edges.
`timescale 1ns/10ps
`default_nettype none
module signal_source #(
   parameter int N = 8                   // Line count
) (
   input  wire logic         pclk,       // Bench clock
   input  wire logic [N-1:0] level,      // Commanded line levels
   input  wire logic         ext_run,    // Run the external timebase
   output logic      [N-1:0] lines,      // Driven lines
   output logic              ext_tb      // Timebase, still when idle
);
   // Lines follow the command; timebase toggles only while running
   initial {lines, ext_tb} = '0;
   always @(posedge pclk) begin
      lines <= level;
      if (ext_run) ext_tb <= !ext_tb;
   end
endmodule // signal_source
`default_nettype wire

// ==== tb/input_glitch_filter_monitor.sv ====
// Port checker for the glitch filter.
// Assumes it is bound to every filter instance.
`timescale 1ns/10ps
`default_nettype none
module input_glitch_filter_monitor
   import glitch_filter_pkg::*;
#(parameter int NUM_LINES = 8) (
   input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_tb,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic [NUM_LINES-1:0] lines_in, lines_out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [NUM_LINES-1:0] p1, p2, p3, po;  // Input history, last output
   // Shift the input history beside the last output
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) {p1, p2, p3, po} <= '0;
      else {p1, p2, p3, po} <= {lines_in, p1, p2, lines_out};
   a_out_cause: assert property (((lines_out^po)&(lines_out^p2)&(lines_out^p3))=='0)
      else $error("line output changed without a matching input");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("ready missing after one wait state");
   a_ready_sel: assert property (pready |-> psel && penable)
      else $error("ready outside an access");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_unmapped_err: assert property (pready && !pwrite && paddr > OFS_STATUS
      |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   a_mapped_ok: assert property (pready && paddr <= OFS_STATUS && paddr[1:0] == 2'b00
      |-> !pslverr)
      else $error("mapped access refused");
   a_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
      else $error("read data changed outside a read");
endmodule // input_glitch_filter_monitor
bind input_glitch_filter input_glitch_filter_monitor #(.NUM_LINES(NUM_LINES)) i_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .pslverr(pslverr), .ext_tb(ext_tb), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .lines_in(lines_in), .lines_out(lines_out));
`default_nettype wire

// ==== tb/input_glitch_filter_tb.sv ====
// Self-checking bench: register setup over APB and pulse trials.
// Assumes the source model drives the lines and the checker is bound.
`timescale 1ns/10ps
`default_nettype none
module input_glitch_filter_tb
   import glitch_filter_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        ext_run, ext_tb;            // Timebase command and line
   logic [7:0]  paddr, level, lines_in, lines_out, prev;
   logic [31:0] pwdata, prdata;
   logic [32:0] q_rd[$];                    // Expected error and read data
   logic [7:0]  q_ln[$];                    // Expected line changes
   int          fails, checks, seed, k, i;
   int          bw[8] = '{2, 10, 2, 102, 25, 2000, 2, 4};      // Blocked widths
   int          hw[8] = '{10, 26, 10, 211, 56, 4006, 11, 26};  // Pass holds
   input_glitch_filter #(.NUM_LINES(8), .LONG_CYC(32'h0000_0032)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lines_in(lines_in), .ext_tb(ext_tb),
      .lines_out(lines_out));
   signal_source #(.N(8)) i_src (.pclk(pclk), .level(level), .ext_run(ext_run),
      .lines(lines_in), .ext_tb(ext_tb));
   // Clock at 40 MHz
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task finish_test;
      if (fails == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [32:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer; reads note their answer first
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] ex);
      if (!w) q_rd.push_back(ex);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Hold the lines at v for n cycles, noting a change when one must pass
   task drive(input logic [7:0] v, input int n, input logic pass);
      if (pass) q_ln.push_back(v);
      level <= v;
      repeat (n) @(posedge pclk);
   endtask
   // Short pulse must vanish, long hold must pass both ways
   task trial(input int b, h, input logic [7:0] m);
      logic [7:0] o;
      o = level;
      drive(o ^ m, b, 1'b0);
      drive(o, h, 1'b0);
      drive(o ^ m, h, 1'b1);
      chk("pending", 33'(q_ln.size()), 33'h0_0000_0000);
      drive(o, h, 1'b1);
   endtask
   // Compare each answer and each line change with the oldest note
   always @(posedge pclk) begin
      if (pready === 1'b1 && pwrite === 1'b0)
         chk("read", {pslverr, prdata}, q_rd.size() ? q_rd.pop_front() : 33'hx);
      if (lines_out !== prev)
         chk("lines", 33'(lines_out), q_ln.size() ? 33'(q_ln.pop_front()) : 33'hx);
      prev = lines_out;
   end
   // Watchdog
   initial begin
      repeat (40000) @(posedge pclk);
      fails++;
      finish_test;
   end
   initial begin
      seed = 32'h8560;
      {psel, penable, pwrite, paddr, pwdata, level, ext_run, prev} = '0;
      fails = 0;
      checks = 0;
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, OFS_CTRL, 0, 33'h0_0000_0001);
      apb(0, OFS_SEL, 0, 33'h0_00B6_DB6D);
      apb(0, 8'h20, 0, 33'h1_0000_0000);
      apb(1, OFS_PAR, 3, 0);
      apb(1, OFS_DIV, 5, 0);
      // Every width code on a random line
      for (k = 0; k < 8; k++) begin
         apb(1, OFS_SEL, {8{k[2:0]}}, 0);
         i = {$random(seed)} % 8;
         trial(bw[k], hw[k], 8'(1 << i));
      end
      apb(1, OFS_CTRL, 3, 0);
      apb(0, OFS_CTRL, 0, 33'h0_0000_0001);
      // Sync only, then no conditioning: one-cycle pulse passes
      for (k = 2; k >= 0; k -= 2) begin
         apb(1, OFS_CTRL, k, 0);
         drive(8'h80, 1, 1'b1);
         drive(8'h00, 6, 1'b1);
      end
      apb(1, OFS_SEL, 0, 0);
      apb(1, OFS_CTRL, 5, 0);
      drive(8'h01, 2, 1'b0);
      drive(8'h03, 20, 1'b1);
      drive(8'h00, 20, 1'b1);
      apb(1, OFS_SEL, 32'h00FF_FFFF, 0);
      apb(1, OFS_CTRL, 9, 0);
      trial(4, 26, 8'h04);
      apb(1, OFS_RATE, 1, 0);
      apb(0, OFS_STATUS, 0, 33'h0_0001_0000);
      drive(8'h10, 60, 1'b0);
      ext_run <= 1'b1;
      drive(8'h10, 60, 1'b1);
      drive(8'h00, 60, 1'b1);
      chk("idle", 33'(q_ln.size() + q_rd.size()), 33'h0_0000_0000);
      finish_test;
   end
endmodule // input_glitch_filter_tb
`default_nettype wire
